// file: design/oscillator_warmup_counter.sv
// oscillator_warmup_counter: cascaded 16-bit warm-up counter with AXI4-Lite register access
// Function
// - on count equal compare, counter clears and, with mask bit 0 set, match request raises together.
// - writing run bit 3 of upper stage control starts count; clearing stops it.
// - slow source, compare 0100H gives about 7.81 ms, FF00H about 1.99 s.
// - fast source, warm-up spans about 16 us to 4.08 ms at FF00H.
// - system control bit 7 fast enable, bit 6 slow enable, bit 5 slow select.
// - lower control 43H selects slow source cascaded, 63H fast source cascaded.
// - upper control 05H selects warm-up mode, toggle flop zero, counter stopped.
// - match uses only upper compare byte; lower compare byte ignored.
// - two 8-bit stages cascade, lower stage carry advances upper stage.
`default_nettype none
module oscillator_warmup_counter
	import warmup_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic fast_osc_clock,
	input wire logic slow_osc_clock,
	input wire logic [warmup_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [warmup_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic fast_osc_enable,
	output logic slow_osc_enable,
	output logic system_clock_slow_select,
	output logic upper_output_toggle_ff,
	output logic lower_output_toggle_ff,
	output logic warmup_match_irq,
	output logic irq
);
	import warmup_pkg::*;

	// ==========================================================
	// reset release
	// the pin reset clears at once; its release is retimed to clk so that every flop
	// leaves reset on the same edge, two edges after the pin rises
	logic [SYNC_STAGES-1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_reg <= '0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[SYNC_STAGES-2:0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[SYNC_STAGES-1];

	// ==========================================================
	// source clock sampling
	// oscillator clocks are sampled as levels; a source must run below clk/2 to be counted
	// edge for edge, so the fast source is only exact when it is slower than half of clk
	// the sampled copies start low, the idle level of a stopped oscillator, so no false edge follows reset
	logic [1:0] fast_sync_reg;
	logic [1:0] slow_sync_reg;
	logic fast_prev_reg;
	logic slow_prev_reg;
	logic fast_tick;
	logic slow_tick;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_sync_reg <= 2'h0;
			slow_sync_reg <= 2'h0;
			fast_prev_reg <= 1'b0;
			slow_prev_reg <= 1'b0;
		end else begin
			fast_sync_reg <= {fast_sync_reg[0], fast_osc_clock};
			slow_sync_reg <= {slow_sync_reg[0], slow_osc_clock};
			fast_prev_reg <= fast_sync_reg[1];
			slow_prev_reg <= slow_sync_reg[1];
		end
	end
	assign fast_tick = fast_sync_reg[1] & ~fast_prev_reg;
	assign slow_tick = slow_sync_reg[1] & ~slow_prev_reg;

	// ==========================================================
	// register map, byte offsets, one aligned word each
	// 00 system_control_two: bit 7 fast oscillator enable, bit 6 slow enable, bit 5 slow select
	// 04 lower_stage_control: bit 7 toggle flop, bits 6:4 source, bits 2:0 mode (011 cascade)
	// 08 upper_stage_control: bit 7 toggle flop, bit 3 run, bits 2:0 mode (101 warm-up)
	// 0C compare: bits 15:8 upper byte, bits 7:0 lower byte, written lane by lane
	// 10 count: image of both stages; a write is answered OKAY and changes nothing
	// 14 interrupt status: bit 0 match flag, write one to clear
	// 18 interrupt mask: bit 0 gates both the match pulse and irq
	// any other offset answers SLVERR and reads as zero

	// ==========================================================
	// registers
	logic [7:0] sys_ctrl_reg;
	logic [7:0] lower_ctrl_reg;
	logic [7:0] upper_ctrl_reg;
	logic [15:0] compare_reg;
	logic [0:0] irq_status_reg;
	logic [0:0] irq_mask_reg;
	// stage_count_reg[0] is the lower stage, stage_count_reg[1] the upper stage
	logic [7:0] stage_count_reg [2];
	logic match_pulse_reg;
	logic irq_reg;

	wire [7:0] compare_upper_byte = compare_reg[15:8];
	wire upper_stage_run = upper_ctrl_reg[RUN_BIT];
	wire [2:0] lower_clk_sel = lower_ctrl_reg[CLK_SEL_LSB +: 3];
	// counting needs both stage modes set; any other pair of modes leaves the count still
	wire warmup_mode = (upper_ctrl_reg[MODE_LSB +: 3] == UPPER_MODE_WARMUP) &&
		(lower_ctrl_reg[MODE_LSB +: 3] == LOWER_MODE_CASCADE);
	// selected source: 100 slow oscillator, 110 fast oscillator, others do not count
	wire source_tick = (lower_clk_sel == CLK_SEL_SLOW) ? slow_tick :
		(lower_clk_sel == CLK_SEL_FAST) ? fast_tick : 1'b0;

	// ==========================================================
	// cascaded counter stages
	// stage 0 counts source edges and stage 1 counts stage 0 wraps; with the two sampling
	// flops and the edge detect a pin edge reaches the count three clk cycles later
	logic [2:0] carry;
	logic [7:0] stage_next [2];
	assign carry[0] = upper_stage_run & warmup_mode & source_tick;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_stage
			assign carry[gi+1] = carry[gi] & (stage_count_reg[gi] == 8'hFF);
			assign stage_next[gi] = carry[gi] ? stage_count_reg[gi] + 8'h01 : stage_count_reg[gi];
		end
	endgenerate

	// lower compare byte plays no part: the match lands when the upper stage reaches the upper
	// byte just as the lower stage wraps to zero, so 0100H means exactly 256 source periods
	wire match_hit = carry[0] && (stage_next[1] == compare_upper_byte) &&
		(stage_next[0] == 8'h00);
	// an upper byte of zero matches only when the full 16-bit count wraps

	// stopping clears both stages at once, so a restart always counts a full warm-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_count_reg[0] <= 8'h00;
			stage_count_reg[1] <= 8'h00;
			match_pulse_reg <= 1'b0;
		end else begin
			if (!upper_stage_run || match_hit) begin
				stage_count_reg[0] <= 8'h00;
				stage_count_reg[1] <= 8'h00;
			end else begin
				stage_count_reg[0] <= stage_next[0];
				stage_count_reg[1] <= stage_next[1];
			end
			match_pulse_reg <= match_hit & irq_mask_reg[MATCH_BIT];
		end
	end

	// ==========================================================
	// AXI4-Lite write channel
	// address and data wait in one-deep slots, taken in either order; the register is
	// written one cycle after both are held, and bvalid rises with that write
	// a new address may be taken while a response waits, but it is applied only once the
	// response has been accepted, so a write never overtakes its own answer
	logic aw_full_reg;
	logic w_full_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;

	wire aw_take = s_axi_awvalid & awready_reg;
	wire w_take = s_axi_wvalid & wready_reg;
	wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire aw_full_next = (aw_full_reg | aw_take) & ~do_write;
	wire w_full_next = (w_full_reg | w_take) & ~do_write;
	wire wr_sys = do_write && (aw_addr_reg == OFS_SYS_CTRL);
	wire wr_lower = do_write && (aw_addr_reg == OFS_LOWER_CTRL);
	wire wr_upper = do_write && (aw_addr_reg == OFS_UPPER_CTRL);
	wire wr_cmp = do_write && (aw_addr_reg == OFS_COMPARE);
	wire wr_stat = do_write && (aw_addr_reg == OFS_IRQ_STATUS);
	wire wr_mask = do_write && (aw_addr_reg == OFS_IRQ_MASK);
	wire wr_count = do_write && (aw_addr_reg == OFS_COUNT);
	// an unmapped offset is still answered, with SLVERR, so a stray write cannot hang the bus
	wire wr_mapped = wr_sys | wr_lower | wr_upper | wr_cmp | wr_stat | wr_mask | wr_count;
	wire lane0 = w_strb_reg[0];
	wire lane1 = w_strb_reg[1];
	wire [0:0] status_clear = (wr_stat && lane0) ? w_data_reg[MATCH_BIT +: 1] : 1'b0;
	// status sets whether or not the mask is on, so software may poll it with irq masked
	// a match in the same cycle as a one-to-clear keeps the flag set
	wire [0:0] status_next = (irq_status_reg & ~status_clear) | {match_hit};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= ~aw_full_next;
			wready_reg <= ~w_full_next;
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			// bresp comes from the held address, so it always belongs to the write it answers
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// control registers
	// stage controls and mask take lane 0 only; the compare lanes are written independently
	// compare may be changed while counting; the new upper byte applies from the next tick
	// irq follows the status as it will stand after this edge, so it rises with the flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_ctrl_reg <= CTRL_RESET;
			lower_ctrl_reg <= CTRL_RESET;
			upper_ctrl_reg <= CTRL_RESET;
			compare_reg <= COMPARE_RESET;
			irq_mask_reg <= 1'b0;
			irq_status_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			if (wr_sys && lane0) begin
				sys_ctrl_reg <= w_data_reg[7:0];
			end
			if (wr_lower && lane0) begin
				lower_ctrl_reg <= w_data_reg[7:0];
			end
			if (wr_upper && lane0) begin
				upper_ctrl_reg <= w_data_reg[7:0];
			end
			if (wr_cmp && lane0) begin
				compare_reg[7:0] <= w_data_reg[7:0];
			end
			if (wr_cmp && lane1) begin
				compare_reg[15:8] <= w_data_reg[15:8];
			end
			if (wr_mask && lane0) begin
				irq_mask_reg <= w_data_reg[MATCH_BIT +: 1];
			end
			irq_status_reg <= status_next;
			irq_reg <= |(status_next & irq_mask_reg);
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	// read data are captured when the address is taken, so a read returns the value of that
	// cycle; arready stays low while an answer waits, one read at a time
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rd_word;
	logic rd_hit;

	wire ar_take = s_axi_arvalid & arready_reg;
	wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			OFS_SYS_CTRL: rd_word[7:0] = sys_ctrl_reg;
			OFS_LOWER_CTRL: rd_word[7:0] = lower_ctrl_reg;
			OFS_UPPER_CTRL: rd_word[7:0] = upper_ctrl_reg;
			OFS_COMPARE: rd_word[15:0] = compare_reg;
			OFS_COUNT: rd_word[15:0] = {stage_count_reg[1], stage_count_reg[0]};
			OFS_IRQ_STATUS: rd_word[0] = irq_status_reg[0];
			OFS_IRQ_MASK: rd_word[0] = irq_mask_reg[0];
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			arready_reg <= ~rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// outputs
	// every output is a register bit or a registered bus signal; nothing combinational leaves
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign fast_osc_enable = sys_ctrl_reg[FAST_EN_BIT];
	assign slow_osc_enable = sys_ctrl_reg[SLOW_EN_BIT];
	assign system_clock_slow_select = sys_ctrl_reg[SYS_SLOW_SEL_BIT];
	// toggle flops only follow their control bits; software holds them at zero here
	assign upper_output_toggle_ff = upper_ctrl_reg[TOGGLE_BIT];
	assign lower_output_toggle_ff = lower_ctrl_reg[TOGGLE_BIT];
	assign warmup_match_irq = match_pulse_reg;
	assign irq = irq_reg;
endmodule
`default_nettype wire

// file: design/warmup_pkg.sv
// package: register map, field positions, reset values and timing figures of the warm-up counter
`default_nettype none
package warmup_pkg;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_SYS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_LOWER_CTRL = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_UPPER_CTRL = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_COMPARE = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h18;
	// system_control_two fields
	localparam int FAST_EN_BIT = 7;
	localparam int SLOW_EN_BIT = 6;
	localparam int SYS_SLOW_SEL_BIT = 5;
	// stage control fields
	localparam int TOGGLE_BIT = 7;
	localparam int CLK_SEL_LSB = 4;
	localparam int RUN_BIT = 3;
	localparam int MODE_LSB = 0;
	localparam logic [2:0] CLK_SEL_SLOW = 3'h4;
	localparam logic [2:0] CLK_SEL_FAST = 3'h6;
	localparam logic [2:0] LOWER_MODE_CASCADE = 3'h3;
	localparam logic [2:0] UPPER_MODE_WARMUP = 3'h5;
	localparam logic [7:0] LOWER_CTRL_SLOW_WARMUP = 8'h43;
	localparam logic [7:0] LOWER_CTRL_FAST_WARMUP = 8'h63;
	localparam logic [7:0] UPPER_CTRL_WARMUP_STOPPED = 8'h05;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] COMPARE_RESET = 16'h0000;
	localparam int MATCH_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// warm-up figures: the count reaches {compare_upper_byte, 8'h00} source ticks
	localparam logic [15:0] COMPARE_MIN = 16'h0100;
	localparam logic [15:0] COMPARE_MAX = 16'hFF00;
	localparam real SLOW_OSC_HZ = 32768.0;
	localparam real SLOW_MIN_MS = 7.81;
	localparam real SLOW_MAX_S = 1.99;
	localparam real FAST_MIN_US = 16.0;
	localparam real FAST_MAX_MS = 4.08;
	localparam int SLOW_MIN_TICKS = int'(SLOW_MIN_MS * SLOW_OSC_HZ / 1000.0 + 0.5);
	localparam int CLK_HZ = 20000000;
	localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// file: testbench/warmup_props.sv
// checker: port-level assertions for the warm-up counter
`default_nettype none
module warmup_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fast_osc_enable,
	input wire logic warmup_match_irq,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========
	// bus handshakes
	a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready after take");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during response");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("no write response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
	// ==========
	// control outputs and match request
	a_fast_enable_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == 5'h00 && s_axi_wstrb[0] |-> ##2 fast_osc_enable == $past(s_axi_wdata[7], 2))
		else $error("fast enable not written");
	a_match_single: assert property (warmup_match_irq |=> !warmup_match_irq) else $error("match pulse too long");
	a_match_irq: assert property (warmup_match_irq |-> ##[0:1] irq) else $error("irq missing on match");
endmodule
bind oscillator_warmup_counter warmup_props i_props (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .fast_osc_enable,
	.warmup_match_irq, .irq);
`default_nettype wire

// file: testbench/oscillator_warmup_counter_tb.sv
// testbench: register access and both warm-up switch sequences
`default_nettype none
module oscillator_warmup_counter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import warmup_pkg::*;
	logic clk, reset_n, fast_osc_clock, slow_osc_clock;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic fast_osc_enable, slow_osc_enable, system_clock_slow_select;
	logic upper_output_toggle_ff, lower_output_toggle_ff, warmup_match_irq, irq;
	int errors, cmp_count, cycles, match_seen;
	oscillator_warmup_counter i_dut (.clk, .reset_n, .fast_osc_clock, .slow_osc_clock, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .fast_osc_enable, .slow_osc_enable, .system_clock_slow_select,
		.upper_output_toggle_ff, .lower_output_toggle_ff, .warmup_match_irq, .irq);
	// ==========
	// shared tasks
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk(s_axi_rdata, exp);
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	// each source edge is held 3 clk high and 3 low, above the 2-flop sampler's minimum
	task automatic src_edges(input bit fast, input int n);
		repeat (n) begin
			if (fast) fast_osc_clock <= 1'b1;
			else slow_osc_clock <= 1'b1;
			repeat (3) @(posedge clk);
			fast_osc_clock <= 1'b0;
			slow_osc_clock <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		for (int i = 0; i < 7; i++) rd(ADDR_W'(4 * i), 32'h0);
		rd(5'h1C, 32'h0, RESP_SLVERR);
		wr(5'h1C, 32'hFF, RESP_SLVERR);
		wr(OFS_COUNT, 32'h1234);
		rd(OFS_COUNT, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_slow;
		wr(OFS_SYS_CTRL, 32'hC0);
		wr(OFS_LOWER_CTRL, 32'h43);
		wr(OFS_UPPER_CTRL, 32'h05);
		chk({upper_output_toggle_ff, lower_output_toggle_ff}, 32'h0);
		rd(OFS_UPPER_CTRL, 32'h05);
		wr(OFS_COMPARE, 32'h02FF);
		wr(OFS_IRQ_MASK, 32'h1);
		wr(OFS_UPPER_CTRL, 32'h0D);
		src_edges(0, 5);
		rd(OFS_COUNT, 32'h5);
		wr(OFS_UPPER_CTRL, 32'h05);
		rd(OFS_COUNT, 32'h0);
		wr(OFS_UPPER_CTRL, 32'h0D);
		src_edges(0, 511);
		rd(OFS_COUNT, 32'h1FF);
		chk(match_seen, 32'h0);
		src_edges(0, 1);
		chk(match_seen, 32'h1);
		chk(irq, 32'h1);
		rd(OFS_COUNT, 32'h0);
		rd(OFS_IRQ_STATUS, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h1);
		@(posedge clk);
		chk(irq, 32'h0);
		wr(OFS_UPPER_CTRL, 32'h05);
		wr(OFS_SYS_CTRL, 32'hE0);
		wr(OFS_SYS_CTRL, 32'h60);
		chk({fast_osc_enable, slow_osc_enable, system_clock_slow_select}, 32'h3);
		$display("test slow done");
	endtask
	task automatic t_fast;
		wr(OFS_SYS_CTRL, 32'hE0);
		wr(OFS_LOWER_CTRL, 32'h63);
		rd(OFS_LOWER_CTRL, 32'h63);
		wr(OFS_COMPARE, 32'h0100);
		wr(OFS_IRQ_MASK, 32'h0);
		wr(OFS_UPPER_CTRL, 32'h0D);
		src_edges(1, 255);
		rd(OFS_COUNT, 32'hFF);
		src_edges(1, 1);
		chk(match_seen, 32'h1);
		chk(irq, 32'h0);
		rd(OFS_IRQ_STATUS, 32'h1);
		wr(OFS_IRQ_MASK, 32'h1);
		@(posedge clk);
		chk(irq, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h1);
		wr(OFS_UPPER_CTRL, 32'h05);
		wr(OFS_SYS_CTRL, 32'hC0);
		wr(OFS_SYS_CTRL, 32'h80);
		chk({fast_osc_enable, slow_osc_enable, system_clock_slow_select}, 32'h4);
		$display("test fast done");
	endtask
	// ==========
	// clock, monitor, main sequence
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (warmup_match_irq === 1'b1) match_seen++;
		if (cycles == 30000) begin
			errors++;
			print_verdict;
		end
	end
	initial begin
		{reset_n, fast_osc_clock, slow_osc_clock, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset;
		t_slow;
		t_fast;
		print_verdict;
	end
endmodule
`default_nettype wire
